// file: hw/gpio_led_pkg.sv
/*
  constants for the twelve-pin gpio/led controller: register map,
  field positions, reset values and sizes.
  assumes a 32-bit apb register bus with word-aligned registers.
*/
package gpio_led_pkg;
  localparam int pin_count = 12;
  localparam int lamp_count = 8;
  localparam int time_width = 64;
  localparam int addr_width = 8;
  localparam int sync_pin_lo = 8;
  localparam int sync_pin_hi = 9;

  // register byte offsets
  localparam logic [7:0] dir_off = 8'h00;
  localparam logic [7:0] od_off = 8'h04;
  localparam logic [7:0] out_off = 8'h08;
  localparam logic [7:0] in_off = 8'h0c;
  localparam logic [7:0] pol_off = 8'h10;
  localparam logic [7:0] edge_off = 8'h14;
  localparam logic [7:0] sts_off = 8'h18;
  localparam logic [7:0] mask_off = 8'h1c;
  localparam logic [7:0] lamp_en_off = 8'h20;
  localparam logic [7:0] cap_ctl_off = 8'h24;
  localparam logic [7:0] cap_lo_off = 8'h28;
  localparam logic [7:0] cap_hi_off = 8'h2c;
  localparam logic [7:0] cmp_lo_off = 8'h30;
  localparam logic [7:0] cmp_hi_off = 8'h34;
  localparam logic [7:0] time_lo_off = 8'h38;
  localparam logic [7:0] time_hi_off = 8'h3c;

  // status layout: bits 11:0 pin events, 12/13 capture, 14 compare
  localparam int cap_evt_bit = 12;
  localparam int cmp_evt_bit = 14;
  localparam int sts_width = 15;
  // capture control: read-only bit 0 shows which time-linked pin fed the capture
  localparam int cap_src_bit = 0;

  localparam logic [31:0] zero_word = 32'h0000_0000;
  localparam logic [11:0] pin_reset = 12'h000;
  localparam logic [7:0] lamp_reset = 8'h00;

  typedef enum logic [1:0] {
    mode_input,
    mode_push_pull,
    mode_open_drain
  } pin_mode_type;
endpackage : gpio_led_pkg

// file: hw/pin_event_detect.sv
/*
  per-pin event detector: level or edge sense with polarity select.
  assumes the pin value is already synchronous to pclk.
*/
`timescale 1ns/100ps
`default_nettype none
module pin_event_detect #(
  parameter int width = 12
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic [width-1:0] pin_value, // sampled pin levels
  input wire logic [width-1:0] polarity, // 1: high/rising, 0: low/falling
  input wire logic [width-1:0] edge_sense, // 1: edge, 0: level
  output logic [width-1:0] event_hit // one-cycle or level event
);
  logic [width-1:0] prev_value;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_value <= '0;
    end else begin
      prev_value <= pin_value;
    end
  end

  genvar i;
  generate
    for (i = 0; i < width; i++) begin : g_evt
      logic active_now;
      logic active_prev;
      assign active_now = pin_value[i] ~^ polarity[i];
      assign active_prev = prev_value[i] ~^ polarity[i];
      assign event_hit[i] = edge_sense[i] ? (active_now & ~active_prev) : active_now;
    end
  endgenerate
endmodule : pin_event_detect
`default_nettype wire

// file: hw/gpio_led_controller.sv
/*
  twelve-pin gpio/led controller with apb registers, pin interrupts,
  time-linked capture and compare on pins 8 and 9, and lamp mode on 7:0.
  assumes pins are synchronous to pclk, and that the 64-bit time value
  and lamp status come from the time unit and the switch ports.
*/
// Operation
// - twelve general-purpose pins, each configured on its own by software
// - each pin is input, push-pull output, or open-drain output pulling low
// - every pin raises an interrupt event with software-chosen polarity or edge
// - time-linked pin as input: its event captures the precise time value
// - time-linked pin as output: driven on a time target-compare event
// - lower eight pins switch by enable from general use to lamp output
// - lamp pins show four status attributes per network port, two ports
// - capture and compare use the common 64-bit tunable time value
`timescale 1ns/100ps
`default_nettype none
module gpio_led_controller
  import gpio_led_pkg::*;
#(
  parameter int pins = pin_count
) (
  input wire logic pclk, // system clock, 250 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [addr_width-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic [pins-1:0] pin_in, // pin input levels
  output logic [pins-1:0] pin_out, // pin output levels
  output logic [pins-1:0] pin_oe, // high while the pin is driven
  input wire logic [time_width-1:0] ptp_time, // common 64-bit tunable clock
  input wire logic [3:0] port_one_status_lamps, // port one status, active high
  input wire logic [3:0] port_two_status_lamps, // port two status, active high
  output logic irq // level interrupt
);
  logic [pins-1:0] dir;
  logic [pins-1:0] open_drain;
  logic [pins-1:0] out_val;
  logic [pins-1:0] polarity;
  logic [pins-1:0] edge_sense;
  logic [lamp_count-1:0] lamp_en;
  logic [sts_width-1:0] status;
  logic [sts_width-1:0] mask;
  logic [time_width-1:0] cap_time;
  logic cap_src;
  logic [time_width-1:0] cmp_time;
  logic [pins-1:0] pin_event;
  logic cmp_hit;
  logic cmp_done;
  logic [1:0] cap_trig;
  logic [sts_width-1:0] set_bits;
  logic wr_en;
  logic rd_en;
  logic addr_ok;

  function automatic logic is_mapped(input logic [addr_width-1:0] a);
    case (a)
      dir_off, od_off, out_off, in_off, pol_off, edge_off, sts_off, mask_off,
      lamp_en_off, cap_ctl_off, cap_lo_off, cap_hi_off, cmp_lo_off, cmp_hi_off,
      time_lo_off, time_hi_off: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // every access completes in its first access cycle
  assign pready = 1'b1;
  assign addr_ok = is_mapped(paddr);
  assign pslverr = psel & penable & ~addr_ok;
  assign wr_en = psel & penable & pwrite & addr_ok;
  assign rd_en = psel & ~penable & ~pwrite;

  pin_event_detect #(
    .width(pins)
  ) u_detect (
    .pclk(pclk),
    .presetn(presetn),
    .pin_value(pin_in),
    .polarity(polarity),
    .edge_sense(edge_sense),
    .event_hit(pin_event)
  );

  // per-pin configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir <= pin_reset;
      open_drain <= pin_reset;
      out_val <= pin_reset;
      polarity <= pin_reset;
      edge_sense <= pin_reset;
      lamp_en <= lamp_reset;
      mask <= '0;
    end else if (wr_en) begin
      case (paddr)
        dir_off: dir <= pwdata[pins-1:0];
        od_off: open_drain <= pwdata[pins-1:0];
        out_off: out_val <= pwdata[pins-1:0];
        pol_off: polarity <= pwdata[pins-1:0];
        edge_off: edge_sense <= pwdata[pins-1:0];
        lamp_en_off: lamp_en <= pwdata[lamp_count-1:0];
        mask_off: mask <= pwdata[sts_width-1:0];
        default: ;
      endcase
    end
  end

  // capture only counts for time-linked pins set as inputs
  assign cap_trig[0] = pin_event[sync_pin_lo] & ~dir[sync_pin_lo];
  assign cap_trig[1] = pin_event[sync_pin_hi] & ~dir[sync_pin_hi];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_time <= '0;
      cap_src <= 1'b0;
    end else if (|cap_trig) begin
      cap_time <= ptp_time;
      cap_src <= cap_trig[1] & ~cap_trig[0];
    end
  end

  capture_time_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (|cap_trig) |=> cap_time == $past(ptp_time))
    else $error("capture did not take the time value");
  capture_flag_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    cap_trig[0] |=> status[cap_evt_bit])
    else $error("capture event not flagged");

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_time <= '0;
    end else if (wr_en && paddr == cmp_lo_off) begin
      cmp_time[31:0] <= pwdata;
    end else if (wr_en && paddr == cmp_hi_off) begin
      cmp_time[63:32] <= pwdata;
    end
  end

  // compare fires once per target; rewriting the target re-arms it
  // writing the low word first can match early against a stale high word
  assign cmp_hit = (ptp_time >= cmp_time) & ~cmp_done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_done <= 1'b1;
    end else if (wr_en && (paddr == cmp_lo_off || paddr == cmp_hi_off)) begin
      cmp_done <= 1'b0;
    end else if (cmp_hit) begin
      cmp_done <= 1'b1;
    end
  end

  compare_once_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (cmp_hit && !(wr_en && (paddr == cmp_lo_off || paddr == cmp_hi_off))) |=> !cmp_hit)
    else $error("compare fired twice");
  compare_arm_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && (paddr == cmp_lo_off || paddr == cmp_hi_off)) |=> !cmp_done)
    else $error("target write did not re-arm compare");

  assign set_bits = {cmp_hit, cap_trig, pin_event};

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
    end else if (wr_en && paddr == sts_off) begin
      status <= (status & ~pwdata[sts_width-1:0]) | set_bits;
    end else begin
      status <= status | set_bits;
    end
  end

  event_sticky_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pin_event[0] |=> status[0])
    else $error("pin event lost");
  status_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (status[3] && !(wr_en && paddr == sts_off && pwdata[3])) |=> status[3])
    else $error("status bit dropped without a clear");
  status_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == sts_off && pwdata[3] && !set_bits[3]) |=> !status[3])
    else $error("write one did not clear status");
  compare_flag_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    cmp_hit |=> status[cmp_evt_bit])
    else $error("compare event not flagged");
  level_event_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!edge_sense[3] && pin_in[3] == polarity[3]) |-> pin_event[3])
    else $error("level event missed");
  edge_event_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (edge_sense[3] && pin_event[3]) |->
      (pin_in[3] == polarity[3] && $past(pin_in[3]) != polarity[3]))
    else $error("edge event without an edge");

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  irq_level_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (|(status & mask)) |=> irq)
    else $error("irq not raised");
  irq_quiet_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(|(status & mask)) |=> !irq)
    else $error("irq raised with nothing pending");

  // pin drive: registered so outputs never glitch on config writes
  logic [pins-1:0] cmp_pulse_out;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_pulse_out <= '0;
    end else begin
      cmp_pulse_out <= '0;
      cmp_pulse_out[sync_pin_lo] <= cmp_hit;
      cmp_pulse_out[sync_pin_hi] <= cmp_hit;
    end
  end

  compare_out_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (cmp_hit && dir[sync_pin_hi] && !open_drain[sync_pin_hi]) |=> ##1 pin_out[sync_pin_hi])
    else $error("compare event not on pin");

  logic [lamp_count-1:0] lamp_status;
  assign lamp_status = {port_two_status_lamps, port_one_status_lamps};

  logic [pins-1:0] level;
  logic [pins-1:0] drive;
  // lamp mode wins over direction and open drain, so a lamp never floats
  logic [pins-1:0] lamp_mode;
  always_comb begin
    level = out_val | cmp_pulse_out;
    drive = dir;
    lamp_mode = '0;
    for (int k = 0; k < lamp_count; k++) begin
      if (lamp_en[k]) begin
        level[k] = ~lamp_status[k];
        drive[k] = 1'b1;
        lamp_mode[k] = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= '0;
      pin_oe <= '0;
    end else begin
      for (int k = 0; k < pins; k++) begin
        // open drain drives only a low and floats otherwise
        if (open_drain[k] && !lamp_mode[k]) begin
          pin_out[k] <= 1'b0;
          pin_oe[k] <= drive[k] & ~level[k];
        end else begin
          pin_out[k] <= level[k];
          pin_oe[k] <= drive[k];
        end
      end
    end
  end

  open_drain_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ($past(open_drain[1]) && !$past(lamp_en[1])) |-> !pin_out[1])
    else $error("open drain pin drove high");
  push_pull_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ($past(dir[0]) && !$past(open_drain[0]) && !$past(lamp_en[0])) |->
      (pin_oe[0] && pin_out[0] == $past(out_val[0])))
    else $error("push-pull pin not driving its level");
  input_float_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ($past(dir[10]) == 1'b0) |-> !pin_oe[10])
    else $error("input pin driven");
  compare_gate_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !$past(dir[sync_pin_hi]) |-> !pin_oe[sync_pin_hi])
    else $error("time-linked input pin driven");
  lamp_low_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (lamp_en[0] && port_one_status_lamps[0]) |=> (pin_oe[0] && !pin_out[0]))
    else $error("active lamp not driven low");
  lamp_high_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (lamp_en[1] && !port_one_status_lamps[1]) |=> (pin_oe[1] && pin_out[1]))
    else $error("idle lamp not driven high");
  lamp_two_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (lamp_en[4] && !port_two_status_lamps[0]) |=> (pin_oe[4] && pin_out[4]))
    else $error("port two lamp on wrong pin");
  lamp_off_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!$past(lamp_en[2]) && !$past(dir[2])) |-> !pin_oe[2])
    else $error("disabled lamp pin still driven");

  // read data registered in the setup cycle, ready in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= zero_word;
    end else if (rd_en) begin
      prdata <= zero_word;
      case (paddr)
        dir_off: prdata[pins-1:0] <= dir;
        od_off: prdata[pins-1:0] <= open_drain;
        out_off: prdata[pins-1:0] <= out_val;
        in_off: prdata[pins-1:0] <= pin_in;
        pol_off: prdata[pins-1:0] <= polarity;
        edge_off: prdata[pins-1:0] <= edge_sense;
        sts_off: prdata[sts_width-1:0] <= status;
        mask_off: prdata[sts_width-1:0] <= mask;
        lamp_en_off: prdata[lamp_count-1:0] <= lamp_en;
        cap_ctl_off: prdata[cap_src_bit] <= cap_src;
        cap_lo_off: prdata <= cap_time[31:0];
        cap_hi_off: prdata <= cap_time[63:32];
        cmp_lo_off: prdata <= cmp_time[31:0];
        cmp_hi_off: prdata <= cmp_time[63:32];
        time_lo_off: prdata <= ptp_time[31:0];
        time_hi_off: prdata <= ptp_time[63:32];
        default: prdata <= zero_word;
      endcase
    end
  end

endmodule : gpio_led_controller
`default_nettype wire

// file: sim/pin_board_model.sv
/*
  board around the twelve pins: pull-ups on every pin, optional drivers.
  assumes pin_out/pin_oe come from the controller.
*/
`timescale 1ns/100ps
`default_nettype none
module pin_board_model #(
  parameter int pins = 12
) (
  input wire logic [pins-1:0] pin_out, // controller levels
  input wire logic [pins-1:0] pin_oe, // controller enables
  input wire logic [pins-1:0] drive_en, // board drives the pin
  input wire logic [pins-1:0] drive_val, // board level
  output logic [pins-1:0] pin_level // resolved wire level
);
  // released pins float up, which an open-drain output relies on
  always_comb begin
    for (int i = 0; i < pins; i++) begin
      pin_level[i] = pin_oe[i] ? pin_out[i] : (drive_en[i] ? drive_val[i] : 1'b1);
    end
  end
endmodule : pin_board_model
`default_nettype wire

// file: sim/tb.sv
/*
  self-checking bench for the gpio/led controller over apb.
  assumes pready answers on its own; the bench waits for it, bounded.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  import gpio_led_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic [11:0] pin_out, pin_oe, pin_level, drive_en = 12'h108, drive_val = 12'h000;
  logic [63:0] ptp_time = 64'h0000_0000_0000_0000;
  logic [3:0] lamps_one = 4'h0, lamps_two = 4'h0;
  int n_errors = 0, compares = 0, cycles = 0, highs;
  logic e;

  always #2 pclk = ~pclk;

  gpio_led_controller u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_level), .pin_out(pin_out), .pin_oe(pin_oe),
    .ptp_time(ptp_time), .port_one_status_lamps(lamps_one),
    .port_two_status_lamps(lamps_two), .irq(irq));

  pin_board_model u_board (.pin_out(pin_out), .pin_oe(pin_oe), .drive_en(drive_en),
    .drive_val(drive_val), .pin_level(pin_level));

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors = n_errors + 1;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge pclk);
  endtask : wait_cycles

  task automatic test_reset;
    apb(0, dir_off, 0); check(q, zero_word); check(e, 0);
    apb(0, lamp_en_off, 0); check(q, zero_word);
    apb(1, 8'hf0, 32'hffff_ffff); check(e, 1);
    apb(0, 8'hf0, 0); check(q, zero_word); check(e, 1);
    check(irq, 0);
    $display("test reset done");
  endtask : test_reset

  task automatic test_irq;
    apb(1, pol_off, 32'h0000_0108); apb(1, edge_off, 32'h0000_0108);
    apb(1, sts_off, 32'h0000_7fff); apb(0, sts_off, 0); check(q, zero_word);
    apb(1, mask_off, 32'h0000_0008);
    drive_val[3] <= 1'b1;
    wait_cycles(3);
    check(irq, 1);
    apb(0, sts_off, 0); check(q & 32'h0000_0008, 32'h0000_0008);
    apb(1, mask_off, 0); wait_cycles(2); check(irq, 0);
    apb(1, mask_off, 32'h0000_0008); wait_cycles(2); check(irq, 1);
    apb(1, sts_off, 32'h0000_0008); wait_cycles(2); check(irq, 0);
    $display("test irq done");
  endtask : test_irq

  task automatic test_outputs;
    apb(1, dir_off, 32'h0000_0003); apb(1, od_off, 32'h0000_0002);
    apb(1, out_off, 32'h0000_0001); wait_cycles(2);
    check(pin_oe[1:0], 2'b11); check(pin_out[1:0], 2'b01);
    apb(1, out_off, 32'h0000_0002); wait_cycles(2);
    check(pin_oe[1:0], 2'b01); check(pin_out[0], 0);
    apb(0, in_off, 0); check(q[1:0], 2'b10);
    $display("test outputs done");
  endtask : test_outputs

  task automatic test_capture;
    ptp_time <= 64'h1234_5678_9abc_def0;
    wait_cycles(2);
    drive_val[8] <= 1'b1;
    wait_cycles(3);
    apb(0, sts_off, 0); check(q[cap_evt_bit], 1);
    apb(0, cap_lo_off, 0); check(q, 32'h9abc_def0);
    apb(0, cap_hi_off, 0); check(q, 32'h1234_5678);
    apb(0, cap_ctl_off, 0); check(q, zero_word);
    $display("test capture done");
  endtask : test_capture

  task automatic test_compare;
    ptp_time <= 64'h0000_0000_0000_0000;
    apb(1, dir_off, 32'h0000_0203); apb(1, out_off, 0);
    apb(1, cmp_hi_off, 32'h0000_0001); apb(1, cmp_lo_off, 0);
    wait_cycles(2); check(pin_out[9], 0);
    apb(0, sts_off, 0); check(q[cmp_evt_bit], 0);
    ptp_time <= 64'h0000_0001_0000_0005;
    highs = 0;
    repeat (12) begin
      @(posedge pclk);
      if (pin_out[9] === 1'b1) highs++;
    end
    check(highs, 1);
    apb(0, sts_off, 0); check(q[cmp_evt_bit], 1);
    $display("test compare done");
  endtask : test_compare

  task automatic test_lamps;
    apb(1, lamp_en_off, 32'h0000_00ff);
    lamps_one <= 4'h5; lamps_two <= 4'ha;
    wait_cycles(2);
    check(pin_oe[7:0], 8'hff); check(pin_out[7:0], 8'h5a);
    lamps_one <= 4'h3; lamps_two <= 4'hc;
    wait_cycles(2);
    check(pin_level[7:0], 8'h3c);
    apb(1, lamp_en_off, 0); wait_cycles(2); check(pin_oe[7:2], 6'h00);
    $display("test lamps done");
  endtask : test_lamps

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_irq();
    test_outputs();
    test_capture();
    test_compare();
    test_lamps();
    give_verdict();
  end
endmodule : tb
`default_nettype wire
